// >>> uef_regs.sv
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uef_regs
	import uef_pkg::*;
(
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          sys_rst,
	// avalon-mm slave
	input  wire logic [7:0]    avs_address,
	input  wire logic          avs_read,
	input  wire logic          avs_write,
	input  wire logic [31:0]   avs_writedata,
	input  wire logic [3:0]    avs_byteenable,
	output logic [31:0]   avs_readdata,
	output logic          avs_waitrequest,
	// link side
	input  wire uef_link_ev_t  link_ev,
	output uef_link_req_t link_req,
	output logic [3:0]    ep_select,
	output logic [7:0]    in_size_limit,
	output logic [1:0]    bus_event_irq
);
	logic [10:0] frame_q;
	logic [3:0]  ep_select_q;
	logic [7:0]  in_size_q [NUM_IN_EP+1];
	logic [7:0]  event_enable_q;
	logic        ep0_stat_q;
	logic        sof_stat_q;
	logic        ack_q;
	logic [7:0]  rd_d;
	logic [7:0]  ctrl_rd;
	logic        ep0_irq;
	logic        req;
	logic        wr_go;
	logic        rd_go;
	logic        wr_lane;

	// size limits exist for endpoints 1 to NUM_IN_EP only; aliased selects must not reach them
	function automatic logic size_sel_ok(input logic [3:0] s);
		return s != 4'h0 && s <= 4'(NUM_IN_EP);
	endfunction : size_sel_ok

	// one wait cycle: request answered on the second edge
	assign req     = (avs_read || avs_write) && !ack_q;
	// writes commit on the edge where waitrequest is already low, never earlier
	assign wr_go   = avs_write && ack_q;
	assign rd_go   = avs_read && !ack_q;
	assign wr_lane = avs_byteenable[0];

	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			ack_q <= 1'b0;
		else
			ack_q <= req;

	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !req;

	// endpoint 0 control and status
	uef_ep0_ctrl u_ep0 (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.wr_ctrl (wr_go && wr_lane && uef_hit(avs_address, IDX_EP0_CTRL)
			&& ep_select_q == 4'h0),
		.wdata   (avs_writedata[7:0]),
		.ev      (link_ev),
		.ctrl_rd (ctrl_rd),
		.ep0_irq (ep0_irq)
	);

	// frame number kept until the next start of frame
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			frame_q <= 11'h000;
		else if (link_ev.sof)
			frame_q <= link_ev.frame;

	// endpoint select
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			ep_select_q <= 4'h0;
		else if (wr_go && wr_lane && uef_hit(avs_address, IDX_EP_SELECT))
			ep_select_q <= avs_writedata[3:0];

	// per-endpoint size limits; endpoint 0 has none
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
		begin
			for (int i = 0; i <= NUM_IN_EP; i++)
				in_size_q[i] <= RST_BYTE;
		end
		else if (wr_go && wr_lane && uef_hit(avs_address, IDX_IN_SIZE)
			&& size_sel_ok(ep_select_q))
			in_size_q[ep_select_q[1:0]] <= avs_writedata[7:0];

	// common event enable
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			event_enable_q <= RST_EVENT_ENABLE;
		else if (wr_go && wr_lane && uef_hit(avs_address, IDX_EVENT_ENABLE))
			event_enable_q <= {3'b000, avs_writedata[4:0]};

	// endpoint status flag: set wins over the read clear
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			ep0_stat_q <= 1'b0;
		else if (ep0_irq)
			ep0_stat_q <= 1'b1;
		else if (rd_go && uef_hit(avs_address, IDX_EP_STATUS))
			ep0_stat_q <= 1'b0;

	// start-of-frame flag, cleared on read of common status
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			sof_stat_q <= 1'b0;
		else if (link_ev.sof)
			sof_stat_q <= 1'b1;
		else if (rd_go && uef_hit(avs_address, IDX_COMMON_STAT))
			sof_stat_q <= 1'b0;

	// gated suspend and resume interrupt outputs
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			bus_event_irq <= 2'b00;
		else
			bus_event_irq <= {link_ev.resume && event_enable_q[BIT_EV_RESUME],
				link_ev.suspend && event_enable_q[BIT_EV_SUSPEND]};

	// read mux; read-only registers have no write path
	always_comb
	begin
		rd_d = 8'h00;
		case (avs_address)
			IDX_FRAME_LOW:    rd_d = frame_q[7:0];
			IDX_FRAME_HIGH:   rd_d = {5'h00, frame_q[10:8]};
			IDX_EP_SELECT:    rd_d = {4'h0, ep_select_q};
			IDX_IN_SIZE:      rd_d = size_sel_ok(ep_select_q)
				? in_size_q[ep_select_q[1:0]] : 8'h00;
			IDX_EP0_CTRL:     rd_d = (ep_select_q == 4'h0) ? ctrl_rd : 8'h00;
			IDX_EP0_TALLY:    rd_d = link_ev.rx_count;
			IDX_EVENT_ENABLE: rd_d = event_enable_q;
			IDX_EP_STATUS:    rd_d = {7'h00, ep0_stat_q};
			IDX_COMMON_STAT:  rd_d = {4'h0, sof_stat_q, 3'b000};
			default:          rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			avs_readdata <= 32'h0000_0000;
		else if (rd_go)
			avs_readdata <= {24'h000000, rd_d};

	// link-facing requests
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			link_req <= '0;
		else
		begin
			link_req.stall_req  <= ctrl_rd[BIT_STALL_REQ];
			link_req.tx_loaded  <= ctrl_rd[BIT_TX_LOADED];
			link_req.last_pkt   <= ctrl_rd[BIT_LAST_PKT];
			link_req.fifo_flush <= link_ev.ctrl_end && !ctrl_rd[BIT_LAST_PKT];
		end

	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			ep_select <= 4'h0;
		else
			ep_select <= ep_select_q;

	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			in_size_limit <= RST_BYTE;
		else
			in_size_limit <= size_sel_ok(ep_select_q)
				? in_size_q[ep_select_q[1:0]] : RST_BYTE;

endmodule : uef_regs
`default_nettype wire

// >>> uef_pkg.sv
// Behaviour
// - enable bits gate resume and suspend interrupts
// - frame low register shows frame bits 7:0
// - frame high register shows frame bits 10:8
// - select field chooses visible endpoint registers
// - each endpoint owns registers, one set mapped
// - per-endpoint in size limit, 8-byte units
// - writing bit 7 clears early-end flag
// - writing bit 6 clears receive-waiting flag
// - bit 5 requests stall, clears after sending
// - early control end sets flag, interrupts, flushes
// - stall-done flag sets, stays until cleared
// - transmit-loaded bit cleared after send, interrupts
// - receive flag sets on packet, interrupts
// - read-only count of received endpoint-0 bytes
// - reading endpoint status clears its flags
// - start-of-frame sets flag, captures frame number
package uef_pkg;

	// register byte addresses; printed offsets are not all multiples of four
	localparam logic [7:0] IDX_FRAME_LOW    = 8'h0c;
	localparam logic [7:0] IDX_FRAME_HIGH   = 8'h0d;
	localparam logic [7:0] IDX_EP_SELECT    = 8'h0e;
	localparam logic [7:0] IDX_IN_SIZE      = 8'h10;
	localparam logic [7:0] IDX_EP0_CTRL     = 8'h11;
	localparam logic [7:0] IDX_EP0_TALLY    = 8'h16;
	localparam logic [7:0] IDX_EVENT_ENABLE = 8'h0b;
	localparam logic [7:0] IDX_EP_STATUS    = 8'h02;
	localparam logic [7:0] IDX_COMMON_STAT  = 8'h06;

	// control register bit positions
	localparam int BIT_EARLY_ACK  = 7;
	localparam int BIT_RX_RELEASE = 6;
	localparam int BIT_STALL_REQ  = 5;
	localparam int BIT_EARLY_END  = 4;
	localparam int BIT_LAST_PKT   = 3;
	localparam int BIT_STALL_DONE = 2;
	localparam int BIT_TX_LOADED  = 1;
	localparam int BIT_RX_WAITING = 0;
	// common interrupt bits
	localparam int BIT_EV_SUSPEND = 0;
	localparam int BIT_EV_RESUME  = 1;
	localparam int BIT_EV_SOF     = 3;

	localparam logic [7:0] RST_EVENT_ENABLE = 8'h06;
	localparam logic [7:0] RST_BYTE         = 8'h00;
	localparam int         NUM_IN_EP        = 3;

	// link-side events from the transaction engine
	typedef struct packed {
		logic        sof;
		logic [10:0] frame;
		logic        rx_done;
		logic [7:0]  rx_count;
		logic        tx_done;
		logic        stall_sent;
		logic        ctrl_end;
		logic        suspend;
		logic        resume;
	} uef_link_ev_t;

	// requests back to the transaction engine
	typedef struct packed {
		logic stall_req;
		logic tx_loaded;
		logic last_pkt;
		logic fifo_flush;
	} uef_link_req_t;

	// register decode: byte address matches index
	function automatic logic uef_hit(input logic [7:0] a, input logic [7:0] idx);
		return a == idx;
	endfunction : uef_hit

endpackage : uef_pkg

// >>> uef_ep0_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module uef_ep0_ctrl
	import uef_pkg::*;
(
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          sys_rst,
	// software write strobe for the control register
	input  wire logic          wr_ctrl,
	input  wire logic [7:0]    wdata,
	// link events
	input  wire uef_link_ev_t  ev,
	// state
	output logic [7:0]    ctrl_rd,
	output logic          ep0_irq
);
	logic early_end_q;
	logic last_pkt_q;
	logic stall_done_q;
	logic tx_loaded_q;
	logic rx_waiting_q;
	logic stall_req_q;

	// early control end: hardware set beats software clear
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			early_end_q <= 1'b0;
		else if (ev.ctrl_end && !last_pkt_q)
			early_end_q <= 1'b1;
		else if (wr_ctrl && wdata[BIT_EARLY_ACK])
			early_end_q <= 1'b0;

	// receive waiting: set on packet, cleared by release bit only
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			rx_waiting_q <= 1'b0;
		else if (ev.rx_done)
			rx_waiting_q <= 1'b1;
		else if (wr_ctrl && wdata[BIT_RX_RELEASE])
			rx_waiting_q <= 1'b0;

	// stall request held until the handshake leaves
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			stall_req_q <= 1'b0;
		else if (ev.stall_sent)
			stall_req_q <= 1'b0;
		else if (wr_ctrl && wdata[BIT_STALL_REQ])
			stall_req_q <= 1'b1;

	// stall done: sticky, software writes zero to clear
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			stall_done_q <= 1'b0;
		else if (ev.stall_sent)
			stall_done_q <= 1'b1;
		else if (wr_ctrl && !wdata[BIT_STALL_DONE])
			stall_done_q <= 1'b0;

	// last packet: software sets, cleared at end of control transfer
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			last_pkt_q <= 1'b0;
		else if (wr_ctrl && wdata[BIT_LAST_PKT])
			last_pkt_q <= 1'b1;
		else if (ev.ctrl_end)
			last_pkt_q <= 1'b0;

	// transmit loaded: software sets, cleared after transmission
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			tx_loaded_q <= 1'b0;
		else if (ev.tx_done || ev.stall_sent)
			tx_loaded_q <= 1'b0;
		else if (wr_ctrl && wdata[BIT_TX_LOADED])
			tx_loaded_q <= 1'b1;

	// endpoint 0 interrupt event pulse
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			ep0_irq <= 1'b0;
		else
			ep0_irq <= (ev.ctrl_end && !last_pkt_q) || ev.rx_done
				|| (ev.tx_done && tx_loaded_q);

	// self-clearing bits 7 and 6 always read zero
	assign ctrl_rd = {2'b00, stall_req_q, early_end_q, last_pkt_q,
		stall_done_q, tx_loaded_q, rx_waiting_q};

endmodule : uef_ep0_ctrl
`default_nettype wire

// >>> uef_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module uef_link_model
	import uef_pkg::*;
(
	// clock
	input  wire logic          sys_clk,
	// transaction engine side
	input  wire uef_link_req_t link_req,
	output var uef_link_ev_t   link_ev
);
	int lag = 1; // answer delay; the bench raises it to test a slow engine
	initial link_ev = '0;
	// one-cycle event; frame and count stay as levels
	task automatic pulse(input int ix, input logic [10:0] f, input logic [7:0] c);
		uef_link_ev_t v;
		v = {1'b0, f, 1'b0, c, 5'h00};
		@(posedge sys_clk);
		link_ev <= v | (26'h1 << ix);
		@(posedge sys_clk);
		link_ev <= v;
	endtask : pulse
	// send the stall or the loaded packet once asked, lag plus one cycles later
	task automatic serve(output logic ok);
		int n;
		n = 0;
		while (!link_req.stall_req && !link_req.tx_loaded && n < 20)
		begin
			@(posedge sys_clk);
			n++;
		end
		ok = n < 20;
		repeat (lag) @(posedge sys_clk);
		pulse(link_req.stall_req ? 3 : 4, link_ev.frame, link_ev.rx_count);
	endtask : serve
endmodule : uef_link_model
`default_nettype wire

// >>> uef_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module uef_regs_chk
	import uef_pkg::*;
(
	// clock and reset
	input wire logic          sys_clk,
	input wire logic          sys_rst,
	// register bus
	input wire logic [7:0]    avs_address,
	input wire logic          avs_read,
	input wire logic          avs_write,
	input wire logic [31:0]   avs_writedata,
	input wire logic [3:0]    avs_byteenable,
	input wire logic [31:0]   avs_readdata,
	input wire logic          avs_waitrequest,
	// link side
	input wire uef_link_ev_t  link_ev,
	input wire uef_link_req_t link_req,
	input wire logic [3:0]    ep_select,
	input wire logic [7:0]    in_size_limit,
	input wire logic [1:0]    bus_event_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic        rd_end;
	logic        wr_end;
	logic [10:0] frame_q;
	// completion edge of an access
	assign rd_end = avs_read && !avs_waitrequest;
	assign wr_end = avs_write && !avs_waitrequest && avs_byteenable[0];
	// last captured frame number
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			frame_q <= 11'h000;
		else if (link_ev.sof)
			frame_q <= link_ev.frame;
	// request lags its register by one edge, so the drop shows two edges on
	sequence stall_gone;
		##2 !link_req.stall_req;
	endsequence
	sequence flush_once;
		link_req.fifo_flush ##1 !link_req.fifo_flush;
	endsequence
	chk_frame_low:
		assert property (rd_end && avs_address == IDX_FRAME_LOW
			|-> avs_readdata[7:0] == $past(frame_q[7:0])) else $error("frame low");
	chk_frame_high:
		assert property (rd_end && avs_address == IDX_FRAME_HIGH
			|-> avs_readdata[7:0] == {5'h00, $past(frame_q[10:8])}) else $error("frame high");
	// the write lands on the completion edge and the output copy follows one edge later
	chk_sel_port:
		assert property (wr_end && avs_address == IDX_EP_SELECT
			|-> ##2 ep_select == $past(avs_writedata[3:0], 2)) else $error("select port");
	chk_ctrl_hidden:
		assert property (rd_end && avs_address == IDX_EP0_CTRL && ep_select != 4'h0
			&& $stable(ep_select) |-> avs_readdata[7:0] == 8'h00) else $error("ctrl shown");
	chk_size_ep0:
		assert property (ep_select == 4'h0 && $past(ep_select) == 4'h0
			|-> in_size_limit == 8'h00) else $error("size on ep0");
	chk_stall_drop:
		assert property (link_ev.stall_sent |-> stall_gone) else $error("stall held");
	// last_pkt on the link shows, one edge late, the flag the design judged by
	chk_flush_pulse:
		assert property (link_ev.ctrl_end ##1 !link_req.last_pkt |-> flush_once)
			else $error("no flush");
	chk_flush_skip:
		assert property (link_ev.ctrl_end ##1 link_req.last_pkt |-> !link_req.fifo_flush)
			else $error("stray flush");
	chk_irq_cause:
		assert property (bus_event_irq[1] |-> $past(link_ev.resume)) else $error("stray irq");
	chk_irq_suspend:
		assert property (bus_event_irq[0] |-> $past(link_ev.suspend))
			else $error("stray suspend");
	chk_size_unmapped:
		assert property (ep_select > 4'(NUM_IN_EP) |-> in_size_limit == 8'h00)
			else $error("size unmapped");
endmodule : uef_regs_chk
bind uef_regs uef_regs_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_ev(link_ev),
	.link_req(link_req), .ep_select(ep_select), .in_size_limit(in_size_limit),
	.bus_event_irq(bus_event_irq));
`default_nettype wire

// >>> tb_uef.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tb
	import uef_pkg::*;
;
	logic          sys_clk;
	logic          sys_rst = 1'b1;
	logic [7:0]    avs_address = 8'h00;
	logic          avs_read = 1'b0;
	logic          avs_write = 1'b0;
	logic [31:0]   avs_writedata = 32'h0;
	logic [3:0]    avs_byteenable = 4'h0;
	logic [31:0]   avs_readdata;
	logic          avs_waitrequest;
	logic [1:0]    bus_event_irq;
	uef_link_ev_t  link_ev;
	uef_link_req_t link_req;
	logic [7:0]    q;
	logic [7:0]    size_out;
	logic          ok;
	int            bad_count = 0;
	int            tests_run = 0;
	uef_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link_ev(link_ev), .link_req(link_req),
		.ep_select(), .in_size_limit(size_out), .bus_event_irq(bus_event_irq));
	uef_link_model lm (.sys_clk(sys_clk), .link_req(link_req), .link_ev(link_ev));
	// system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// one access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		avs_read <= !w;
		avs_write <= w;
		// waitrequest and read data are taken at the rising edge, release follows it
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest && n < 50);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
		begin
			bad_count++;
			tally_and_finish();
		end
	endtask : bus
	task automatic rd(input logic [7:0] a, e, input string n);
		bus(1'b0, a, 8'h00, 4'hf);
		`CHK(n, e, q)
	endtask : rd
	// event pulse, then gather the interrupt lines for a few cycles
	task automatic ev_irq(input int ix, input logic [1:0] e);
		logic [1:0] s;
		s = 2'b00;
		lm.pulse(ix, link_ev.frame, 8'h00);
		repeat (3)
		begin
			@(negedge sys_clk);
			s = s | bus_event_irq;
		end
		`CHK("irq", e, s)
	endtask : ev_irq
	task automatic t_frame();
		rd(IDX_FRAME_LOW, RST_BYTE, "flo");
		rd(IDX_EVENT_ENABLE, RST_EVENT_ENABLE, "ena");
		rd(8'h20, 8'h00, "hole");
		lm.pulse(25, 11'h5a3, 8'h00);
		rd(IDX_FRAME_HIGH, 8'h05, "fhi");
		rd(IDX_COMMON_STAT, 8'h08, "sof");
		rd(IDX_COMMON_STAT, 8'h00, "sof2");
		bus(1'b1, IDX_FRAME_LOW, 8'h11, 4'h1);
		rd(IDX_FRAME_LOW, 8'ha3, "flo2");
		$display("frame test done");
	endtask : t_frame
	task automatic t_select();
		bus(1'b1, IDX_EP_SELECT, 8'hf2, 4'h1);
		bus(1'b1, IDX_IN_SIZE, 8'h07, 4'h1);
		bus(1'b1, IDX_EP_SELECT, 8'h03, 4'h0);
		rd(IDX_EP_SELECT, 8'h02, "sel");
		rd(IDX_EP0_CTRL, 8'h00, "hid");
		bus(1'b1, IDX_EP_SELECT, 8'h03, 4'h1);
		rd(IDX_IN_SIZE, 8'h00, "sz3");
		bus(1'b1, IDX_EP_SELECT, 8'h02, 4'h1);
		rd(IDX_IN_SIZE, 8'h07, "sz2");
		`CHK("lim2", 8'h07, size_out)
		bus(1'b1, IDX_EP_SELECT, 8'h06, 4'h1);
		rd(IDX_IN_SIZE, 8'h00, "sz6");
		`CHK("lim6", 8'h00, size_out)
		bus(1'b1, IDX_EP_SELECT, 8'h00, 4'h1);
		bus(1'b1, IDX_IN_SIZE, 8'h06, 4'h1);
		rd(IDX_IN_SIZE, 8'h00, "sz0");
		$display("select test done");
	endtask : t_select
	task automatic t_ep0();
		lm.pulse(13, link_ev.frame, 8'h12);
		rd(IDX_EP0_CTRL, 8'h01, "rxw");
		bus(1'b1, IDX_EP_SELECT, 8'h01, 4'h1);
		rd(IDX_EP0_CTRL, 8'h00, "hid1");
		bus(1'b1, IDX_EP_SELECT, 8'h00, 4'h1);
		rd(IDX_EP0_TALLY, 8'h12, "cnt");
		rd(IDX_EP_STATUS, 8'h01, "epi");
		rd(IDX_EP_STATUS, 8'h00, "epi2");
		bus(1'b1, IDX_EP0_CTRL, 8'h40, 4'h1);
		rd(IDX_EP0_CTRL, 8'h00, "rel");
		lm.lag = 6;
		bus(1'b1, IDX_EP0_CTRL, 8'h20, 4'h1);
		rd(IDX_EP0_CTRL, 8'h20, "stq");
		lm.serve(ok);
		`CHK("srv0", 1'b1, ok)
		rd(IDX_EP0_CTRL, 8'h04, "std");
		bus(1'b1, IDX_EP0_CTRL, 8'h00, 4'h1);
		rd(IDX_EP0_CTRL, 8'h00, "stc");
		lm.lag = 1;
		bus(1'b1, IDX_EP0_CTRL, 8'h0a, 4'h1);
		lm.serve(ok);
		`CHK("srv", 1'b1, ok)
		rd(IDX_EP0_CTRL, 8'h08, "txd");
		rd(IDX_EP_STATUS, 8'h01, "txi");
		lm.pulse(2, link_ev.frame, 8'h00);
		rd(IDX_EP0_CTRL, 8'h00, "end1");
		rd(IDX_EP_STATUS, 8'h00, "eni1");
		lm.pulse(2, link_ev.frame, 8'h00);
		rd(IDX_EP0_CTRL, 8'h10, "end2");
		rd(IDX_EP_STATUS, 8'h01, "eni2");
		bus(1'b1, IDX_EP0_CTRL, 8'h80, 4'h1);
		rd(IDX_EP0_CTRL, 8'h00, "ack");
		$display("endpoint 0 test done");
	endtask : t_ep0
	task automatic t_events();
		ev_irq(0, 2'b10);
		ev_irq(1, 2'b00);
		bus(1'b1, IDX_EVENT_ENABLE, 8'h01, 4'h1);
		ev_irq(1, 2'b01);
		ev_irq(0, 2'b00);
		$display("event test done");
	endtask : t_events
	// reset in mid-run after a capture: frame and enables go back to reset values
	task automatic t_reset();
		lm.pulse(25, 11'h3c5, 8'h00);
		rd(IDX_FRAME_LOW, 8'hc5, "flo3");
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(IDX_FRAME_LOW, RST_BYTE, "frst");
		rd(IDX_EVENT_ENABLE, RST_EVENT_ENABLE, "erst");
		$display("reset test done");
	endtask : t_reset
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	// reset for eight cycles, then the scenarios
	initial
	begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_frame();
		t_select();
		t_ep0();
		t_events();
		t_reset();
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
